//--- src/jcp_cfg.svh
`ifndef JCP_CFG_SVH
`define JCP_CFG_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define JCP_A_CTRL    8'h00
`define JCP_A_CHAIN   8'h04
`define JCP_A_DATA    8'h08
`define JCP_A_LEN     8'h0c
`define JCP_A_STATUS  8'h10
`define JCP_A_CAPT    8'h14
`define JCP_A_TRACE   8'h18

// ----------------------------------------
// Control fields
// ----------------------------------------
`define JCP_C_START   0
`define JCP_C_IR      1
`define JCP_C_SWD     2
`define JCP_C_RST     3
`define JCP_C_CLS     4
`define JCP_C_DRV     5
`define JCP_C_DIV_LO  8
`define JCP_C_DIV_HI  15

// ----------------------------------------
// Chain fields
// ----------------------------------------
`define JCP_CH_DB_LO  0
`define JCP_CH_DB_HI  3
`define JCP_CH_DA_LO  4
`define JCP_CH_DA_HI  7
`define JCP_CH_IB_LO  8
`define JCP_CH_IB_HI  16
`define JCP_CH_IA_LO  17
`define JCP_CH_IA_HI  25

// ----------------------------------------
// Status fields
// ----------------------------------------
`define JCP_S_BUSY    0
`define JCP_S_DONE    1
`define JCP_S_CFGERR  2
`define JCP_S_OVF     3
`define JCP_S_CNT_LO  4
`define JCP_S_CNT_HI  8
`define JCP_S_LOVR    9
`define JCP_T_VALID   8

// ----------------------------------------
// Limits, sequences, reset values
// ----------------------------------------
`define JCP_IR_MAX    10'd256
`define JCP_IR_8BIT   6'd4
`define JCP_IR_32BIT  6'd5
`define JCP_LEN_MAX   6'd32
`define JCP_IR_PRE    4'b0011
`define JCP_DR_PRE    4'b0001
`define JCP_NPRE_IR   3'd4
`define JCP_NPRE_DR   3'd3
`define JCP_POST_SEQ  2'b01
`define JCP_NPOST     3'd2
`define JCP_DIV_RST   8'h04
`define JCP_DIV_MIN   8'h02
`define JCP_TRC_LAST  4'hf
`define JCP_TRC_HALF  4'h7
`define JCP_TRC_STOP  4'h9

`endif

//--- src/jcp_pkg.sv
package jcp_pkg;

  typedef enum logic [0:0] {
    JCP_IDLE = 1'b0,
    JCP_RUN  = 1'b1
  } jcp_st_t;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       busy;
    logic [3:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] data;
    logic       req;
    logic       a1;
    logic       a2;
    logic       ovr;
  } jcp_rx_t;

  typedef struct packed {
    jcp_st_t         st;
    logic            ir_scan;
    logic            swd;
    logic            swd_drv;
    logic            cls;
    logic            srst_n;
    logic [7:0]      div;
    logic [3:0]      dev_before;
    logic [3:0]      dev_after;
    logic [8:0]      ir_before;
    logic [8:0]      ir_after;
    logic [5:0]      len;
    logic [31:0]     wdat;
    logic [31:0]     cap;
    logic            done;
    logic            cfg_err;
    logic            ovf;
    logic [7:0]      hcnt;
    logic [9:0]      step;
    logic            tck;
    logic            tms;
    logic            tms_oe;
    logic            tdi;
    logic            tdo_s1;
    logic            tdo_s2;
    logic            tmsi_s1;
    logic            tmsi_s2;
    logic            req_s1;
    logic            req_s2;
    logic            req_s3;
    logic            ack;
    logic            ovr_s1;
    logic            ovr_s2;
    logic [15:0][7:0] fifo;
    logic [4:0]      wp;
    logic [4:0]      rp;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } jcp_regs_t;

endpackage : jcp_pkg

//--- src/jcp_trace_rx.sv
`timescale 1ns/1ps
`include "jcp_cfg.svh"

module jcp_trace_rx (
  input  wire logic       trace_clk,
  input  wire logic       presetn,
  input  wire logic       trace_input_pin,
  input  wire logic       ack_tgl,
  output logic            req_tgl,
  output logic [7:0]      rx_byte,
  output logic            rx_ovr
);
  import jcp_pkg::*;

  jcp_rx_t r_q;
  jcp_rx_t r_d;

  always_comb begin
    r_d    = r_q;
    r_d.s1 = trace_input_pin;
    r_d.s2 = r_q.s1;
    r_d.a1 = ack_tgl;
    r_d.a2 = r_q.a1;
    if (!r_q.busy) begin
      if (!r_q.s2) begin
        r_d.busy = 1'b1;
        r_d.cnt  = `JCP_TRC_HALF;
        r_d.bitn = 4'h0;
      end
    end else if (r_q.cnt != 4'h0) begin
      r_d.cnt = r_q.cnt - 4'h1;
    end else begin
      r_d.cnt = `JCP_TRC_LAST;
      if (r_q.bitn == 4'h0) begin
        // Glitch shorter than half a bit is not a start
        if (r_q.s2) begin
          r_d.busy = 1'b0;
        end else begin
          r_d.bitn = 4'h1;
        end
      end else if (r_q.bitn != `JCP_TRC_STOP) begin
        r_d.sh   = {r_q.s2, r_q.sh[7:1]};
        r_d.bitn = r_q.bitn + 4'h1;
      end else begin
        r_d.busy = 1'b0;
        if (r_q.s2) begin
          // Byte handed over only once the last one was taken
          if (r_q.req == r_q.a2) begin
            r_d.data = r_q.sh;
            r_d.req  = ~r_q.req;
          end else begin
            r_d.ovr = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge trace_clk or negedge presetn) begin
    if (!presetn) begin
      r_q    <= '0;
      r_q.s1 <= 1'b1;
      r_q.s2 <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign req_tgl = r_q.req;
  assign rx_byte = r_q.data;
  assign rx_ovr  = r_q.ovr;

endmodule : jcp_trace_rx

//--- src/jcp_probe.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "jcp_cfg.svh"

// Summary of operation
// R1: TCK and TMS fan out in parallel; TDI to TDO runs serially.
// R2: Devices-before count programs the bypass bits shifted after target data.
// R3: Devices-after count programs bypass bits ahead of target data.
// R4: Instruction bits before and after set the IR padding on each side.
// R5: Instruction path over 256 bits is refused with a configuration error; the 10-bit sum wraps, so paths of 1024 bits or more pass.
// R6: Device counts on each side are held to fifteen at most.
// R7: Target IR length is four bits for 8-bit class, five for 32-bit.
// R8: Two-wire mode drives clock on TCK and data on TMS only.
// R9: Trace bytes from the trace input pin are buffered then read out.
// R10: Software can hold the whole chain in reset via the reset output.
// R11: IR padding shifts ones; DR scans add one bypass bit per device.
// R12: Probe drives TCK, TMS, TDI and samples TDO from the chain.
module jcp_probe (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tdo_in,
  input  wire logic        tms_in,
  output logic             tck_out,
  output logic             tms_out,
  output logic             tms_oe,
  output logic             tdi_out,
  output logic             chain_system_reset_out_n,
  input  wire logic        trace_clk,
  input  wire logic        trace_input_pin
);
  import jcp_pkg::*;

  // ----------------------------------------
  // State and link-side receiver
  // ----------------------------------------
  jcp_regs_t r_q;
  jcp_regs_t r_d;

  logic       rx_req;
  logic [7:0] rx_byte;
  logic       rx_ovr;

  jcp_trace_rx u_rx (
    .trace_clk       (trace_clk),
    .presetn         (presetn),
    .trace_input_pin (trace_input_pin),
    .ack_tgl         (r_q.ack),
    .req_tgl         (rx_req),
    .rx_byte         (rx_byte),
    .rx_ovr          (rx_ovr)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    reg_idx = a[4:2];
  endfunction : reg_idx

  function automatic logic reg_ok(input logic [7:0] a);
    reg_ok = (a[1:0] == 2'b00) && (a <= `JCP_A_TRACE);
  endfunction : reg_ok

  function automatic logic [5:0] tgt_ir(input logic cls);
    tgt_ir = cls ? `JCP_IR_32BIT : `JCP_IR_8BIT; // R7
  endfunction : tgt_ir

  // Returns {tms, tdi} for one step of the scan stream
  function automatic logic [1:0] drive(
    input logic [9:0]  s,
    input logic [2:0]  npre,
    input logic [9:0]  post,
    input logic [5:0]  n,
    input logic [9:0]  tot,
    input logic        ir,
    input logic        swd,
    input logic [31:0] dat
  );
    logic [9:0] k;
    logic [9:0] kk;
    logic [9:0] kp;
    logic       tm;
    logic       ti;
    logic [3:0] pre;
    logic [1:0] pst;
    pre = ir ? `JCP_IR_PRE : `JCP_DR_PRE;
    pst = `JCP_POST_SEQ;
    k  = s - {7'd0, npre};
    kk = k - post;
    kp = k - tot;
    tm = 1'b0;
    ti = 1'b1;
    if (swd) begin
      tm = dat[s[4:0]]; // R8
    end else if (s < {7'd0, npre}) begin
      tm = pre[s[1:0]];
    end else if (k < tot) begin
      tm = (k == tot - 10'd1);
      if (k >= post && kk < {4'd0, n}) begin
        ti = dat[kk[4:0]];
      end
      // Otherwise ones: bypass pattern in every pad position
    end else begin
      tm = pst[kp[0]];
    end
    drive = {tm, ti};
  endfunction : drive

  // ----------------------------------------
  // Scan geometry
  // ----------------------------------------
  logic [9:0] g_post;
  logic [9:0] g_pre;
  logic [5:0] g_n;
  logic [2:0] g_npre;
  logic [2:0] g_npost;
  logic [9:0] g_tot;
  logic [9:0] g_steps;
  logic [9:0] g_irsum;

  // First bits shifted travel furthest, so after-side pads lead
  assign g_post  = r_q.swd ? 10'd0 :
                   r_q.ir_scan ? {1'b0, r_q.ir_after} : {6'd0, r_q.dev_after}; // R3 R4 R11
  assign g_pre   = r_q.swd ? 10'd0 :
                   r_q.ir_scan ? {1'b0, r_q.ir_before} : {6'd0, r_q.dev_before}; // R2 R4 R11
  assign g_n     = (r_q.ir_scan && !r_q.swd) ? tgt_ir(r_q.cls) : r_q.len;
  assign g_npre  = r_q.swd ? 3'd0 : r_q.ir_scan ? `JCP_NPRE_IR : `JCP_NPRE_DR;
  assign g_npost = r_q.swd ? 3'd0 : `JCP_NPOST;
  assign g_tot   = g_post + {4'd0, g_n} + g_pre;
  assign g_steps = {7'd0, g_npre} + g_tot + {7'd0, g_npost};
  assign g_irsum = {1'b0, r_q.ir_before} + {1'b0, r_q.ir_after}
                 + {4'd0, tgt_ir(r_q.cls)};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [9:0]  k;
    logic [9:0]  kk;
    logic [1:0]  dv;
    logic        setup;
    logic        wr;
    logic        rd;
    logic [4:0]  cnt;
    logic [7:0]  dv8;
    k     = '0;
    kk    = '0;
    dv    = '0;
    dv8   = '0;
    r_d   = r_q;
    cnt   = r_q.wp - r_q.rp;
    setup = psel && !penable;
    wr    = psel && penable && r_q.pready && !r_q.pslverr && pwrite;
    rd    = psel && penable && r_q.pready && !r_q.pslverr && !pwrite;

    // Pin synchronisers
    r_d.tdo_s1  = tdo_in;
    r_d.tdo_s2  = r_q.tdo_s1;
    r_d.tmsi_s1 = tms_in;
    r_d.tmsi_s2 = r_q.tmsi_s1;
    r_d.req_s1  = rx_req;
    r_d.req_s2  = r_q.req_s1;
    r_d.req_s3  = r_q.req_s2;
    r_d.ovr_s1  = rx_ovr;
    r_d.ovr_s2  = r_q.ovr_s1;

    // Trace bytes into the buffer; full drops and flags
    if (r_q.req_s2 != r_q.req_s3) begin
      r_d.ack = r_q.req_s2;
      if (cnt[4]) begin
        r_d.ovf = 1'b1; // R9
      end else begin
        r_d.fifo[r_q.wp[3:0]] = rx_byte; // R9
        r_d.wp = r_q.wp + 5'd1;
      end
    end

    // Scan engine: TCK high and low halves each div+1 cycles
    unique case (r_q.st)
      JCP_IDLE: begin
        r_d.tck = 1'b0;
      end
      JCP_RUN: begin
        if (r_q.hcnt != 8'h00) begin
          r_d.hcnt = r_q.hcnt - 8'h01;
        end else begin
          r_d.hcnt = r_q.div;
          if (!r_q.tck) begin
            r_d.tck = 1'b1; // R1 R12
          end else begin
            // Sample late in the high half, well after TDO settled
            k  = r_q.step - {7'd0, g_npre};
            kk = k - g_post;
            if (r_q.swd) begin
              if (!r_q.swd_drv) begin
                r_d.cap[r_q.step[4:0]] = r_q.tmsi_s2; // R8
              end
            end else if (r_q.step >= {7'd0, g_npre} && k < g_tot
                         && k >= g_post && kk < {4'd0, g_n}) begin
              r_d.cap[kk[4:0]] = r_q.tdo_s2; // R12
            end
            r_d.tck  = 1'b0;
            r_d.step = r_q.step + 10'd1;
            if (r_q.step + 10'd1 == g_steps) begin
              r_d.st     = JCP_IDLE;
              r_d.done   = 1'b1;
              r_d.tms    = 1'b0;
              r_d.tdi    = 1'b1;
              r_d.tms_oe = 1'b1;
            end else begin
              dv = drive(r_q.step + 10'd1, g_npre, g_post, g_n, g_tot,
                         r_q.ir_scan, r_q.swd, r_q.wdat);
              r_d.tms = dv[1];
              r_d.tdi = dv[0];
            end
          end
        end
      end
    endcase

    // APB: answer registered in setup, pready high in access
    r_d.pready  = setup;
    r_d.pslverr = setup && !reg_ok(paddr);
    if (setup) begin
      r_d.prdata = 32'h0000_0000;
      if (reg_ok(paddr)) begin
        unique case (reg_idx(paddr))
          3'd0: begin
            r_d.prdata[`JCP_C_IR]  = r_q.ir_scan;
            r_d.prdata[`JCP_C_SWD] = r_q.swd;
            r_d.prdata[`JCP_C_RST] = !r_q.srst_n;
            r_d.prdata[`JCP_C_CLS] = r_q.cls;
            r_d.prdata[`JCP_C_DRV] = r_q.swd_drv;
            r_d.prdata[`JCP_C_DIV_HI:`JCP_C_DIV_LO] = r_q.div;
          end
          3'd1: begin
            r_d.prdata[`JCP_CH_DB_HI:`JCP_CH_DB_LO] = r_q.dev_before;
            r_d.prdata[`JCP_CH_DA_HI:`JCP_CH_DA_LO] = r_q.dev_after;
            r_d.prdata[`JCP_CH_IB_HI:`JCP_CH_IB_LO] = r_q.ir_before;
            r_d.prdata[`JCP_CH_IA_HI:`JCP_CH_IA_LO] = r_q.ir_after;
          end
          3'd2: r_d.prdata = r_q.wdat;
          3'd3: r_d.prdata[5:0] = r_q.len;
          3'd4: begin
            r_d.prdata[`JCP_S_BUSY]   = (r_q.st == JCP_RUN);
            r_d.prdata[`JCP_S_DONE]   = r_q.done;
            r_d.prdata[`JCP_S_CFGERR] = r_q.cfg_err;
            r_d.prdata[`JCP_S_OVF]    = r_q.ovf;
            r_d.prdata[`JCP_S_CNT_HI:`JCP_S_CNT_LO] = cnt;
            r_d.prdata[`JCP_S_LOVR]   = r_q.ovr_s2;
          end
          3'd5: r_d.prdata = r_q.cap;
          3'd6: begin
            r_d.prdata[7:0] = r_q.fifo[r_q.rp[3:0]];
            r_d.prdata[`JCP_T_VALID] = (cnt != 5'd0);
          end
          3'd7: r_d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // Trace read pops at the access edge
    if (rd && reg_idx(paddr) == 3'd6 && cnt != 5'd0) begin
      r_d.rp = r_q.rp + 5'd1; // R9
    end

    // Status clears lose against a set in the same cycle
    if (wr && reg_idx(paddr) == 3'd4) begin
      if (pwdata[`JCP_S_DONE] && !r_d.done) begin
        r_d.done = 1'b0;
      end
      if (pwdata[`JCP_S_DONE]) begin
        r_d.done = r_d.done && !(r_q.st == JCP_IDLE && r_q.done);
      end
      if (pwdata[`JCP_S_CFGERR]) begin
        r_d.cfg_err = 1'b0;
      end
      if (pwdata[`JCP_S_OVF] && !(r_q.req_s2 != r_q.req_s3 && cnt[4])) begin
        r_d.ovf = 1'b0;
      end
    end

    // Configuration is frozen while a scan runs
    if (wr && r_q.st == JCP_IDLE) begin
      unique case (reg_idx(paddr))
        3'd0: begin
          r_d.ir_scan = pwdata[`JCP_C_IR];
          r_d.swd     = pwdata[`JCP_C_SWD];
          r_d.srst_n  = !pwdata[`JCP_C_RST]; // R10
          r_d.cls     = pwdata[`JCP_C_CLS];
          r_d.swd_drv = pwdata[`JCP_C_DRV];
          dv8 = pwdata[`JCP_C_DIV_HI:`JCP_C_DIV_LO];
          // Floor keeps the two-flop TDO delay inside a half period
          r_d.div = (dv8 < `JCP_DIV_MIN) ? `JCP_DIV_MIN : dv8;
        end
        3'd1: begin
          // Four-bit fields cap each side at fifteen devices
          r_d.dev_before = pwdata[`JCP_CH_DB_HI:`JCP_CH_DB_LO]; // R6
          r_d.dev_after  = pwdata[`JCP_CH_DA_HI:`JCP_CH_DA_LO]; // R6
          r_d.ir_before  = pwdata[`JCP_CH_IB_HI:`JCP_CH_IB_LO];
          r_d.ir_after   = pwdata[`JCP_CH_IA_HI:`JCP_CH_IA_LO];
        end
        3'd2: r_d.wdat = pwdata;
        3'd3: r_d.len  = pwdata[5:0];
        default: begin
        end
      endcase
    end

    // Start launches only if IR, SWD and CLS match the settings already held
    if (wr && r_q.st == JCP_IDLE && reg_idx(paddr) == 3'd0
        && pwdata[`JCP_C_START]) begin
      if (pwdata[`JCP_C_IR] && !pwdata[`JCP_C_SWD] && g_irsum > `JCP_IR_MAX) begin
        r_d.cfg_err = 1'b1; // R5
      end else if ((!pwdata[`JCP_C_IR] || pwdata[`JCP_C_SWD])
                   && (r_q.len == 6'd0 || r_q.len > `JCP_LEN_MAX)) begin
        r_d.cfg_err = 1'b1;
      end else if (r_q.ir_scan == pwdata[`JCP_C_IR] && r_q.swd == pwdata[`JCP_C_SWD]
                   && r_q.cls == pwdata[`JCP_C_CLS]) begin
        r_d.st     = JCP_RUN;
        r_d.done   = 1'b0;
        r_d.step   = 10'd0;
        r_d.hcnt   = r_d.div;
        r_d.tck    = 1'b0;
        r_d.cap    = 32'h0000_0000;
        r_d.tms_oe = !(pwdata[`JCP_C_SWD] && !pwdata[`JCP_C_DRV]); // R8
        dv = drive(10'd0,
                   pwdata[`JCP_C_SWD] ? 3'd0 :
                   pwdata[`JCP_C_IR] ? `JCP_NPRE_IR : `JCP_NPRE_DR,
                   g_post, g_n, g_tot, pwdata[`JCP_C_IR],
                   pwdata[`JCP_C_SWD], r_q.wdat);
        r_d.tms = dv[1];
        r_d.tdi = dv[0];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q        <= '0;
      r_q.srst_n <= 1'b1;
      r_q.tms_oe <= 1'b1;
      r_q.tdi    <= 1'b1;
      r_q.div    <= `JCP_DIV_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata                   = r_q.prdata;
  assign pready                   = r_q.pready;
  assign pslverr                  = r_q.pslverr;
  assign tck_out                  = r_q.tck;
  assign tms_out                  = r_q.tms;
  assign tms_oe                   = r_q.tms_oe;
  assign tdi_out                  = r_q.tdi;
  assign chain_system_reset_out_n = r_q.srst_n;

endmodule : jcp_probe

//--- tb/jcp_probe_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Probe port checks
// ----------------------------------------
module jcp_probe_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tck_out,
  input wire logic        tms_out,
  input wire logic        tdi_out,
  input wire logic        chain_system_reset_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup, bad, wacc;
  assign setup = psel && !penable;
  assign bad = paddr > 8'h18 || paddr[1:0] != 2'h0;
  assign wacc = pready && pwrite;
  property p_ans; setup |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_bad; setup && bad |=> pslverr && prdata == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped access not refused");
  property p_good; setup && !bad |=> !pslverr; endproperty
  a_good: assert property (p_good) else $error("mapped access refused");
  property p_tckh; $rose(tck_out) |-> tck_out [*3]; endproperty
  a_tckh: assert property (p_tckh) else $error("test clock high too short");
  property p_tckl; $fell(tck_out) |-> !tck_out [*3]; endproperty
  a_tckl: assert property (p_tckl) else $error("test clock low too short");
  property p_hold; tck_out |-> $stable(tms_out) && $stable(tdi_out); endproperty
  a_hold: assert property (p_hold) else $error("tms or tdi moved while clock high");
  property p_rst;
    $changed(chain_system_reset_out_n) |-> $past(wacc) || $past(wacc, 2);
  endproperty
  a_rst: assert property (p_rst) else $error("chain reset moved without a write");
endmodule : jcp_probe_props

bind jcp_probe jcp_probe_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tck_out(tck_out), .tms_out(tms_out), .tdi_out(tdi_out),
  .chain_system_reset_out_n(chain_system_reset_out_n));

//--- tb/jcp_chain_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Chain and trace source model
// ----------------------------------------
module jcp_chain_model #(
  parameter int DEPTH = 2
) (
  input  wire logic tck,
  input  wire logic tdi,
  input  wire logic tms,
  input  wire logic tms_oe,
  input  wire logic trace_clk,
  output logic      tdo,
  output logic      tms_in,
  output logic      trace_pin
);
  // Bypass-only chain, so captured bits are delayed copies of TDI
  logic [DEPTH-1:0] sr = '1;
  logic             alt = 1'b0;
  initial tdo = 1'b1;
  initial trace_pin = 1'b1;
  always @(posedge tck) sr <= {sr[DEPTH-2:0], tdi};
  always @(negedge tck) begin
    tdo <= sr[DEPTH-1];
    alt <= ~alt;
  end
  // Released line toggles so a stale value cannot pass
  assign tms_in = tms_oe ? tms : alt;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge trace_clk);
      trace_pin <= f[i];
      repeat (15) @(posedge trace_clk);
    end
  endtask : send
endmodule : jcp_chain_model

//--- tb/jtag_chain_probe_port_bench.sv
`timescale 1ns/1ps
`include "jcp_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
// ----------------------------------------
// Probe bench
// ----------------------------------------
module jtag_chain_probe_port_bench;
  import jcp_pkg::*;
  localparam int D = 2;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, tclk = '0;
  logic [7:0]  paddr = '0, tq[$];
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, tdo, tmsi, tck, tms, oe, tdi, rst_n, trc, err;
  int          fail_count = 0, compares = 0, seed = 91498;
  logic        th[$], mh[$], ih[$];
  always #25 pclk = ~pclk;
  initial begin
    #3;
    forever #6 tclk = ~tclk;
  end
  jcp_probe i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tdo_in(tdo), .tms_in(tmsi), .tck_out(tck), .tms_out(tms),
    .tms_oe(oe), .tdi_out(tdi), .chain_system_reset_out_n(rst_n), .trace_clk(tclk),
    .trace_input_pin(trc));
  jcp_chain_model #(.DEPTH(D)) i_chain (.tck(tck), .tdi(tdi), .tms(tms), .tms_oe(oe),
    .trace_clk(tclk), .tdo(tdo), .tms_in(tmsi), .trace_pin(trc));
  always @(posedge tck) begin
    th.push_back(tdi);
    mh.push_back(tms);
    ih.push_back(tmsi);
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_done();
    q = '0;
    while (q[`JCP_S_DONE] !== 1'b1) apb(1'b0, `JCP_A_STATUS, '0);
    apb(1'b1, `JCP_A_STATUS, 32'h6);
  endtask : wait_done
  task automatic start(input logic [31:0] c);
    apb(1'b1, `JCP_A_CTRL, c);
    apb(1'b1, `JCP_A_CTRL, c | 32'h1);
  endtask : start
  task automatic scan(input logic ir, input logic cls, input int a, input int b, input int n);
    int s0, p, l;
    logic [31:0] d, c, m;
    logic [3:0] pv;
    if (ir) n = cls ? 5 : 4;
    d = $random(seed);
    s0 = th.size();
    p = ir ? 4 : 3;
    pv = ir ? 4'b0011 : 4'b0001;
    l = a + n + b;
    m = (n == 32) ? '1 : ((32'h1 << n) - 32'h1);
    apb(1'b1, `JCP_A_CHAIN, 32'(ir ? (b << 8 | a << 17) : (b | a << 4)));
    apb(1'b1, `JCP_A_DATA, d);
    apb(1'b1, `JCP_A_LEN, 32'(n));
    start(32'(32'h200 | ir << 1 | cls << 4));
    wait_done();
    `CHK(th.size() - s0, p + l + 2)
    for (int j = 0; j < p + l + 2; j++) begin
      `CHK(mh[s0+j], j < p ? pv[j] : (j < p + l ? j == p + l - 1 : j == p + l))
      if (j >= p && j < p + l)
        `CHK(th[s0+j], (j - p < a || j - p >= a + n) ? 1'b1 : d[j-p-a])
    end
    c = '0;
    for (int i = 0; i < n; i++) c[i] = th[s0+p+a+i-D];
    apb(1'b0, `JCP_A_CAPT, '0);
    `CHK(q & m, c)
  endtask : scan
  task automatic refuse(input logic ir, input int b, input int n);
    int s0;
    s0 = th.size();
    apb(1'b1, `JCP_A_CHAIN, 32'(b << 8));
    apb(1'b1, `JCP_A_LEN, 32'(n));
    start(32'(32'h200 | ir << 1));
    apb(1'b0, `JCP_A_STATUS, '0);
    `CHK(q[2:0], 3'b100)
    `CHK(th.size(), s0)
    apb(1'b1, `JCP_A_STATUS, 32'h6);
  endtask : refuse
  task automatic two_wire(input logic drv, input int n);
    int s0;
    logic [31:0] d, c;
    d = $random(seed);
    s0 = th.size();
    apb(1'b1, `JCP_A_LEN, 32'(n));
    apb(1'b1, `JCP_A_DATA, d);
    start(32'(32'h204 | drv << 5));
    @(posedge tck);
    `CHK(oe, drv)
    wait_done();
    `CHK(th.size() - s0, n)
    for (int j = 0; j < n; j++) begin
      `CHK(th[s0+j], 1'b1)
      if (drv) `CHK(mh[s0+j], d[j])
    end
    if (!drv) begin
      c = '0;
      for (int j = 0; j < n; j++) c[j] = ih[s0+j];
      apb(1'b0, `JCP_A_CAPT, '0);
      `CHK(q, c)
    end
  endtask : two_wire
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #2ms;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({tck, oe, tdi, rst_n}, 4'b0111)
    apb(1'b0, 8'h1c, '0);
    `CHK({err, q}, {1'b1, 32'h0})
    apb(1'b1, 8'h02, '0);
    `CHK(err, 1'b1)
    apb(1'b1, `JCP_A_CTRL, 32'h208);
    `CHK(rst_n, 1'b0)
    apb(1'b1, `JCP_A_CTRL, 32'h200);
    `CHK(rst_n, 1'b1)
    scan(1'b0, 1'b0, 1, 1, 8);
    scan(1'b0, 1'b0, 0, 15, 32);
    scan(1'b0, 1'b0, 15, 0, 1);
    scan(1'b1, 1'b0, 5, 4, 0);
    scan(1'b1, 1'b1, 0, 0, 0);
    scan(1'b1, 1'b0, 5, 247, 0);
    refuse(1'b1, 253, 4);
    refuse(1'b0, 0, 0);
    refuse(1'b0, 0, 33);
    two_wire(1'b1, 12);
    two_wire(1'b0, 7);
    for (int k = 0; k < 17; k++) begin
      tq.push_back(8'($random(seed)));
      i_chain.send(tq[k]);
    end
    repeat (10) @(posedge pclk);
    apb(1'b0, `JCP_A_STATUS, '0);
    `CHK(q[9:3], 7'h21)
    for (int k = 0; k < 16; k++) begin
      apb(1'b0, `JCP_A_TRACE, '0);
      `CHK(q[8:0], {1'b1, tq[k]})
    end
    apb(1'b0, `JCP_A_TRACE, '0);
    `CHK(q[8], 1'b0)
    apb(1'b1, `JCP_A_STATUS, 32'h8);
    apb(1'b0, `JCP_A_STATUS, '0);
    `CHK(q[9:3], 7'h00)
    stop_test();
  end
endmodule : jtag_chain_probe_port_bench
